/* verification/hbd_spi_master.sv */
// SPI master model that frames control words and collects status words
`timescale 1ns/1ps
module hbd_spi_master
    import hbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic miso_i,
    output hbd_spi_in_s spi_o
);
    initial spi_o = 3'b100;
    // shutdown enable rides in the word
    task automatic xfer(input logic [15:0] tx, input int nb, input int hp,
        output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk_i);
        spi_o.chip_select_n = 1'b0;
        repeat (8) @(negedge clk_i);
        for (int i = nb - 1; i >= 0; i--) begin
            spi_o.mosi = tx[i];
            repeat (hp) @(negedge clk_i);
            spi_o.sck = 1'b1;
            rx = {rx[14:0], miso_i};
            repeat (hp) @(negedge clk_i);
            spi_o.sck = 1'b0;
        end
        repeat (hp) @(negedge clk_i);
        spi_o.chip_select_n = 1'b1;
        spi_o.mosi = ~spi_o.mosi;
        repeat (12) @(negedge clk_i);
    endtask
endmodule

/* verification/hbd_status_properties.sv */
// Assertions on the diagnosis status block ports
`timescale 1ns/1ps
module hbd_status_chk
    import hbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire hbd_spi_in_s spi_i,
    input wire logic miso_o,
    input wire hbd_sense_s sense_i,
    input wire hbd_bridge_s stage_i,
    input wire hbd_bridge_s bridge_cmd_o,
    input wire logic [NUM_BRIDGES-1:0] bridge_off_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_oc_bridge_off: assert property (
        |sense_i.overcurrent |-> ##2 &(bridge_off_o | ~$past(sense_i.overcurrent, 2)))
        else $error("overcurrent bridge not off");
    chk_oc_no_drive: assert property (
        |sense_i.overcurrent |-> ##2 (bridge_cmd_o.active & $past(sense_i.overcurrent, 2)) == 0)
        else $error("overcurrent bridge still driven");
    chk_supply_all_off: assert property (
        sense_i.supply_fault [*2] |=> bridge_cmd_o.active == 0)
        else $error("bridge driven during supply fault");
    chk_hot_all_off: assert property (
        sense_i.temp_shutdown [*2] |=> bridge_cmd_o.active == 0)
        else $error("bridge driven above shutdown temperature");
    chk_off_held: assert property (
        |($past(bridge_off_o) & ~bridge_off_o)
        && !$past(sense_i.supply_fault || sense_i.temp_shutdown, 2)
        |-> spi_i.chip_select_n)
        else $error("shutdown released inside a frame");
    chk_conf_at_select: assert property (
        $changed(bridge_cmd_o.polarity) |-> spi_i.chip_select_n)
        else $error("control applied inside a frame");
    chk_off_has_cause: assert property (
        |(bridge_off_o & ~$past(bridge_off_o))
        |-> |$past(sense_i.overcurrent | sense_i.open_load, 2)
        || $past(sense_i.supply_fault || sense_i.temp_shutdown))
        else $error("shutdown without a fault");
    chk_miso_idle: assert property (
        spi_i.chip_select_n [*8] |-> !miso_o)
        else $error("serial output busy while idle");
    cover property ($fell(bridge_off_o[0]));
    cover property ($rose(spi_i.chip_select_n));
    cover property (sense_i.temp_shutdown);
endmodule

bind hbd_status hbd_status_chk u_hbd_status_chk(.clk_i(clk_i), .reset_i(reset_i),
    .spi_i(spi_i), .miso_o(miso_o), .sense_i(sense_i), .stage_i(stage_i),
    .bridge_cmd_o(bridge_cmd_o), .bridge_off_o(bridge_off_o));

/* verification/test_hbd_status.sv */
// Self-checking bench of the diagnosis status word block
`timescale 1ns/1ps
module test_hbd_status
    import hbd_pkg::*;
;
    typedef struct packed {
        hbd_sense_s s;
        hbd_bridge_s b;
        logic [15:0] c;
        logic [15:0] e;
    } hbd_row_s;
    localparam hbd_row_s ROWS [7] = '{
        '{'{6'h01, 6'h00, 1'b1, 1'b1, 1'b0}, '{6'h3f, 6'h15}, 16'h0000, 16'h4001},
        '{'0, '{6'h2a, 6'h15}, 16'h8000, 16'h952a},
        '{'0, '{6'h15, 6'h2a}, 16'h1f80, 16'h0ad4},
        '{'{6'h00, 6'h02, 1'b0, 1'b1, 1'b0}, '0, 16'h0000, 16'h2001},
        '{'{6'h00, 6'h00, 1'b0, 1'b0, 1'b1}, '0, 16'h0000, 16'h2000},
        '{'{6'h00, 6'h00, 1'b1, 1'b0, 1'b0}, '0, 16'h8000, 16'h6000},
        '{'0, '0, 16'h0000, 16'h0000}
    };
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    hbd_sense_s sense = '0;
    hbd_bridge_s stage = '0;
    hbd_spi_in_s spi;
    hbd_bridge_s cmd;
    logic [5:0] off;
    logic miso;
    logic [15:0] rx;
    int bad_count = 0;
    int total_checks = 0;
    always #10 clk_i = ~clk_i;
    hbd_spi_master u_hbd_spi_master(.clk_i(clk_i), .miso_i(miso), .spi_o(spi));
    hbd_status u_hbd_status(.clk_i(clk_i), .reset_i(reset_i), .spi_i(spi), .miso_o(miso),
        .sense_i(sense), .stage_i(stage), .bridge_cmd_o(cmd), .bridge_off_o(off));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Latched faults are shown as short pulses
    task automatic pulse(input logic [5:0] oc, input logic [5:0] ol);
        sense.overcurrent = oc;
        sense.open_load = ol;
        repeat (3) @(negedge clk_i);
        sense.overcurrent = 6'h00;
        sense.open_load = 6'h00;
        repeat (2) @(negedge clk_i);
    endtask
    initial begin
        #400000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        foreach (ROWS[i]) begin
            sense = ROWS[i].s;
            stage = ROWS[i].b;
            pulse(ROWS[i].s.overcurrent, ROWS[i].s.open_load);
            u_hbd_spi_master.xfer(ROWS[i].c, 16, 8, rx);
            check(rx, ROWS[i].e);
        end
        pulse(6'h00, 6'h02);
        check({10'h000, off}, 16'h0000);
        u_hbd_spi_master.xfer(16'h2000, 16, 8, rx);
        check(rx, 16'h2000);
        pulse(6'h00, 6'h04);
        check({10'h000, off}, 16'h0004);
        pulse(6'h01, 6'h00);
        u_hbd_spi_master.xfer(16'hffff, 8, 20, rx);
        u_hbd_spi_master.xfer(16'h0000, 16, 20, rx);
        check(rx, 16'ha000);
        reset_i = 1'b1;
        repeat (3) @(negedge clk_i);
        reset_i = 1'b0;
        check({4'h0, cmd}, 16'h0000);
        check({10'h000, off}, 16'h0000);
        stage = '{6'h3f, 6'h15};
        u_hbd_spi_master.xfer(16'h1faa, 16, 8, rx);
        check(rx, 16'h0000);
        check({4'h0, cmd}, 16'h0fd5);
        sense.temp_shutdown = 1'b1;
        repeat (3) @(negedge clk_i);
        check({4'h0, cmd}, 16'h0015);
        check({10'h000, off}, 16'h003f);
        sense.temp_shutdown = 1'b0;
        repeat (3) @(negedge clk_i);
        u_hbd_spi_master.xfer(16'h0000, 16, 8, rx);
        check(rx, 16'h1faa);
        print_verdict;
    end
endmodule

/* verilog/hbd_pkg.sv */
// Package of constants and types for the half-bridge diagnosis status word
// Behaviour
// - Overcurrent sets bit 15, bridge switched off
// - Overcurrent flag clears only by request/reset
// - Supply fault sets bit 14, all off
// - Supply fault flag follows supply, self-clearing
// - Open load sets and latches bit 13
// - Open load switches off only if enabled
// - Open-load flag clears only by request/reset
// - Bits 12..7 show actual bridge activation
// - Bits 6..1 show actual bridge polarity
// - Status shows driver stages, not control
// - Thermal warning sets bit 0
// - Shutdown temperature switches all bridges off
// - Thermal warning clears when cooled down
// - First word: live fault and warning only
// - Clear request clears latches at select rise
package hbd_pkg;
    localparam int NUM_BRIDGES = 6;
    localparam int WORD_BITS = 16;
    localparam int OC_BIT = 15;
    localparam int SF_BIT = 14;
    localparam int OL_BIT = 13;
    localparam int ACT_LSB = 7;
    localparam int POL_LSB = 1;
    localparam int TW_BIT = 0;
    localparam int CTL_CLEAR_BIT = 15;
    localparam int CTL_OL_SD_BIT = 13;
    localparam int CTL_ACT_LSB = 7;
    localparam int CTL_POL_LSB = 1;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [3:0] BIT_CNT_LAST = 4'hf;

    typedef struct packed {
        logic [NUM_BRIDGES-1:0] overcurrent;
        logic [NUM_BRIDGES-1:0] open_load;
        logic supply_fault;
        logic temp_warning;
        logic temp_shutdown;
    } hbd_sense_s;

    typedef struct packed {
        logic [NUM_BRIDGES-1:0] active;
        logic [NUM_BRIDGES-1:0] polarity;
    } hbd_bridge_s;

    typedef struct packed {
        logic chip_select_n;
        logic sck;
        logic mosi;
    } hbd_spi_in_s;
endpackage

/* verilog/hbd_status.sv */
// Diagnosis status word, SPI shift path and bridge gating of the hex half-bridge driver
`timescale 1ns/1ps
module hbd_status
    import hbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire hbd_spi_in_s spi_i,
    output logic miso_o,
    input wire hbd_sense_s sense_i,
    input wire hbd_bridge_s stage_i,
    output hbd_bridge_s bridge_cmd_o,
    output logic [NUM_BRIDGES-1:0] bridge_off_o
);
    // Three-stage synchronisers for the SPI pins
    logic [2:0] csn_sync_q;
    logic [2:0] sck_sync_q;
    logic [2:0] mosi_sync_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            csn_sync_q <= 3'h7;
            sck_sync_q <= 3'h0;
            mosi_sync_q <= 3'h0;
        end else begin
            csn_sync_q <= {csn_sync_q[1:0], spi_i.chip_select_n};
            sck_sync_q <= {sck_sync_q[1:0], spi_i.sck};
            mosi_sync_q <= {mosi_sync_q[1:0], spi_i.mosi};
        end
    end

    logic csn_q;
    logic sck_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            csn_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            if (csn_sync_q[1] == csn_sync_q[2]) begin
                csn_q <= csn_sync_q[2];
            end
            if (sck_sync_q[1] == sck_sync_q[2]) begin
                sck_q <= sck_sync_q[2];
            end
        end
    end

    logic csn_new;
    logic sck_new;
    logic frame_start;
    logic frame_end;
    logic sck_rise;
    logic sck_fall;
    assign csn_new = (csn_sync_q[1] == csn_sync_q[2]) ? csn_sync_q[2] : csn_q;
    assign sck_new = (sck_sync_q[1] == sck_sync_q[2]) ? sck_sync_q[2] : sck_q;
    assign frame_start = csn_q && !csn_new;
    assign frame_end = !csn_q && csn_new;
    assign sck_rise = !csn_q && !sck_q && sck_new;
    assign sck_fall = !csn_q && sck_q && !sck_new;

    // Latched faults
    logic oc_q;
    logic ol_q;
    logic first_word_q;
    logic [WORD_BITS-1:0] ctl_q;
    logic [WORD_BITS-1:0] rx_q;
    logic [3:0] bit_cnt_q;
    logic frame_full_q;
    logic clear_req;
    assign clear_req = frame_end && frame_full_q && rx_q[CTL_CLEAR_BIT];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            oc_q <= 1'b0;
        end else if (|sense_i.overcurrent) begin
            oc_q <= 1'b1;
        end else if (clear_req) begin
            oc_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ol_q <= 1'b0;
        end else if (|sense_i.open_load) begin
            ol_q <= 1'b1;
        end else if (clear_req) begin
            ol_q <= 1'b0;
        end
    end

    // Per-bridge latched shutdowns, released by clear request
    logic [NUM_BRIDGES-1:0] oc_off_q;
    logic [NUM_BRIDGES-1:0] ol_off_q;
    genvar b;
    generate
        for (b = 0; b < NUM_BRIDGES; b++) begin : g_bridge
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    oc_off_q[b] <= 1'b0;
                end else if (sense_i.overcurrent[b]) begin
                    oc_off_q[b] <= 1'b1;
                end else if (clear_req) begin
                    oc_off_q[b] <= 1'b0;
                end
            end
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    ol_off_q[b] <= 1'b0;
                end else if (sense_i.open_load[b] && ctl_q[CTL_OL_SD_BIT]) begin
                    ol_off_q[b] <= 1'b1;
                end else if (clear_req) begin
                    ol_off_q[b] <= 1'b0;
                end
            end
        end
    endgenerate

    logic all_off;
    assign all_off = sense_i.supply_fault || sense_i.temp_shutdown;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bridge_off_o <= '0;
            bridge_cmd_o <= '0;
        end else begin
            bridge_off_o <= oc_off_q | ol_off_q | {NUM_BRIDGES{all_off}};
            bridge_cmd_o.active <= ctl_q[CTL_ACT_LSB +: NUM_BRIDGES]
                & ~(oc_off_q | ol_off_q | {NUM_BRIDGES{all_off}});
            bridge_cmd_o.polarity <= ctl_q[CTL_POL_LSB +: NUM_BRIDGES];
        end
    end

    // Receive path: control word taken on sck rise
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_q <= STATUS_RESET;
            bit_cnt_q <= '0;
            frame_full_q <= 1'b0;
        end else if (frame_start) begin
            bit_cnt_q <= '0;
            frame_full_q <= 1'b0;
        end else if (sck_rise) begin
            rx_q <= {rx_q[WORD_BITS-2:0], mosi_sync_q[2]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == BIT_CNT_LAST) begin
                frame_full_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctl_q <= STATUS_RESET;
        end else if (frame_end && frame_full_q) begin
            ctl_q <= rx_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_word_q <= 1'b1;
        end else if (frame_end && frame_full_q) begin
            first_word_q <= 1'b0;
        end
    end

    // Status word assembly
    logic [WORD_BITS-1:0] status_word;
    always_comb begin
        status_word = STATUS_RESET;
        status_word[SF_BIT] = sense_i.supply_fault;
        status_word[TW_BIT] = sense_i.temp_warning;
        // first word holds only live flags
        if (!first_word_q) begin
            status_word[OC_BIT] = oc_q;
            status_word[OL_BIT] = ol_q;
            status_word[ACT_LSB +: NUM_BRIDGES] = stage_i.active;
            status_word[POL_LSB +: NUM_BRIDGES] = stage_i.polarity;
        end
    end

    logic [WORD_BITS-1:0] tx_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_q <= STATUS_RESET;
        end else if (frame_start) begin
            tx_q <= status_word;
        end else if (sck_fall) begin
            tx_q <= {tx_q[WORD_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            miso_o <= 1'b0;
        end else if (frame_start) begin
            miso_o <= status_word[WORD_BITS-1];
        end else if (sck_fall) begin
            miso_o <= tx_q[WORD_BITS-2];
        end else if (csn_q) begin
            miso_o <= 1'b0;
        end
    end
endmodule
